// file: inc/vtar_pkg.sv
// constants and types shared by the vlan table access register block
package vtar_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam int VTAR_ADDR_W = 16;
    localparam logic [15:0] VTAR_OFF_WORD0 = 16'h0400;
    localparam logic [15:0] VTAR_OFF_UNTAG = 16'h0404;
    localparam logic [15:0] VTAR_OFF_FWD = 16'h0408;
    localparam logic [15:0] VTAR_OFF_POINTER = 16'h040C;
    localparam logic [15:0] VTAR_OFF_CMD = 16'h040E;

    // ----------------------------------------------------------------
    // field positions and widths in the register words
    // ----------------------------------------------------------------
    localparam int VTAR_VALID_BIT = 31;
    localparam int VTAR_SEL_BIT = 27;
    localparam int VTAR_PRIO_LSB = 24;
    localparam int VTAR_MSTI_LSB = 12;
    localparam int VTAR_FGID_LSB = 0;
    localparam int VTAR_MAP_LSB = 0;
    localparam int VTAR_PTR_LSB = 0;
    localparam int VTAR_START_BIT = 7;
    localparam int VTAR_ACT_LSB = 0;
    localparam int VTAR_PRIO_W = 3;
    localparam int VTAR_MSTI_W = 3;
    localparam int VTAR_FGID_W = 7;
    localparam int VTAR_MAP_W = 7;
    localparam int VTAR_PTR_W = 12;

    // ----------------------------------------------------------------
    // table storage layout: {valid, sel, prio, msti, fgid, untag, fwd}
    // ----------------------------------------------------------------
    localparam int VTAR_ENTRY_W = 29;
    localparam int VTAR_TABLE_DEPTH = 4096;
    localparam logic [11:0] VTAR_LAST_ROW = 12'hFFF;
    localparam int VTAR_E_VALID = 28;
    localparam int VTAR_E_SEL = 27;
    localparam int VTAR_E_PRIO = 24;
    localparam int VTAR_E_MSTI = 21;
    localparam int VTAR_E_FGID = 14;
    localparam int VTAR_E_UNTAG = 7;
    localparam int VTAR_E_FWD = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] VTAR_RST_PRIO = 3'h0;
    localparam logic [2:0] VTAR_RST_MSTI = 3'h0;
    localparam logic [6:0] VTAR_RST_MAP = 7'h00;
    localparam logic [11:0] VTAR_RST_PTR = 12'h000;
    localparam logic [28:0] VTAR_ZERO_ENTRY = 29'h0000_0000;

    // ----------------------------------------------------------------
    // actions and sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NOP = 2'h0,
        ACT_WRITE = 2'h1,
        ACT_READ = 2'h2,
        ACT_CLEAR = 2'h3
    } vtar_action_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RDWAIT = 3'h2,
        ST_CLEAR = 3'h4
    } vtar_state_e;
endpackage

// file: src/vtar_table_ram.sv
// single-port vlan table storage with registered read data
`timescale 1ns/100ps
module vtar_table_ram (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ram_we,
    input wire logic ram_re,
    input wire logic [11:0] ram_addr,
    input wire logic [28:0] ram_wdata,
    output logic [28:0] ram_rdata
);
    // ----------------------------------------------------------------
    // storage array
    // ----------------------------------------------------------------
    logic [28:0] mem [0:vtar_pkg::VTAR_TABLE_DEPTH-1];

    // array has no reset; the clear action sweeps it instead
    always_ff @(posedge ref_clk) begin
        if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
    end

    // read data stand one cycle after the address
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_rdata <= vtar_pkg::VTAR_ZERO_ENTRY;
        end else if (ram_re) begin
            ram_rdata <= mem[ram_addr];
        end
    end
endmodule // vtar_table_ram

// file: src/vtar_regs.sv
// vlan table access registers, action sequencer and lookup port
`timescale 1ns/100ps
// Functional notes
// - word0 bit 31 marks entry valid
// - selector set: forward to entry port map
// - selector clear: use other port sources
// - 3-bit priority in word0 bits 26:24
// - spanning instance index in bits 14:12
// - 7-bit filter group in bits 6:0
// - untag map bit n is port n+1
// - forward map applies only when selector set
// - pointer bits 11:0 address the table
// - start bit self-clears when action completes
// - action 00 nop, 01 write, 10 read
// - action 11 clears whole table to zero
module vtar_regs (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic lkup_req,
    input wire logic [11:0] lkup_row,
    input wire logic [6:0] lkup_alt_map,
    output logic lkup_ready,
    output logic lkup_valid,
    output logic lkup_hit,
    output logic [6:0] lkup_fwd_map,
    output logic [6:0] lkup_untag_map,
    output logic [2:0] lkup_prio,
    output logic [2:0] spanning_instance_sel,
    output logic [6:0] filter_group_ident
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic valid_reg;
    logic entry_map_select;
    logic [2:0] prio_reg;
    logic [2:0] msti_reg;
    logic [6:0] fgid_reg;
    logic [6:0] untag_reg;
    logic [6:0] fwd_reg;
    logic [11:0] table_row_pointer;
    vtar_pkg::vtar_action_e action_reg;
    logic start_reg;
    vtar_pkg::vtar_state_e st_reg;
    logic [11:0] sweep_reg;
    logic lk_pend_reg;
    logic [6:0] lk_alt_reg;
    logic ram_we;
    logic ram_re;
    logic [11:0] ram_addr;
    logic [28:0] ram_wdata;
    logic [28:0] ram_rdata;
    logic go;
    logic lk_take;

    // address match used by the write and read decoders
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    // entry registers packed into one table row
    function automatic logic [28:0] pack_row(
        input logic v, input logic s, input logic [2:0] p, input logic [2:0] m,
        input logic [6:0] f, input logic [6:0] u, input logic [6:0] w);
        return {v, s, p, m, f, u, w};
    endfunction

    // ----------------------------------------------------------------
    // entry word registers
    // ----------------------------------------------------------------
    // a completed read overwrites software's copy of the entry
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_reg <= 1'h0;
            entry_map_select <= 1'h0;
            prio_reg <= vtar_pkg::VTAR_RST_PRIO;
            msti_reg <= vtar_pkg::VTAR_RST_MSTI;
            fgid_reg <= vtar_pkg::VTAR_RST_MAP;
        end else if (st_reg == vtar_pkg::ST_RDWAIT) begin
            valid_reg <= ram_rdata[vtar_pkg::VTAR_E_VALID];
            entry_map_select <= ram_rdata[vtar_pkg::VTAR_E_SEL];
            prio_reg <= ram_rdata[vtar_pkg::VTAR_E_PRIO +: 3];
            msti_reg <= ram_rdata[vtar_pkg::VTAR_E_MSTI +: 3];
            fgid_reg <= ram_rdata[vtar_pkg::VTAR_E_FGID +: 7];
        end else if (reg_wr && hit(reg_addr, vtar_pkg::VTAR_OFF_WORD0)) begin
            valid_reg <= reg_wdata[vtar_pkg::VTAR_VALID_BIT];
            entry_map_select <= reg_wdata[vtar_pkg::VTAR_SEL_BIT];
            prio_reg <= reg_wdata[vtar_pkg::VTAR_PRIO_LSB +: 3];
            msti_reg <= reg_wdata[vtar_pkg::VTAR_MSTI_LSB +: 3];
            fgid_reg <= reg_wdata[vtar_pkg::VTAR_FGID_LSB +: 7];
        end
    end

    // port maps: untag and forward words
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            untag_reg <= vtar_pkg::VTAR_RST_MAP;
            fwd_reg <= vtar_pkg::VTAR_RST_MAP;
        end else if (st_reg == vtar_pkg::ST_RDWAIT) begin
            untag_reg <= ram_rdata[vtar_pkg::VTAR_E_UNTAG +: 7];
            fwd_reg <= ram_rdata[vtar_pkg::VTAR_E_FWD +: 7];
        end else if (reg_wr) begin
            if (hit(reg_addr, vtar_pkg::VTAR_OFF_UNTAG)) begin
                untag_reg <= reg_wdata[vtar_pkg::VTAR_MAP_LSB +: 7];
            end
            if (hit(reg_addr, vtar_pkg::VTAR_OFF_FWD)) begin
                fwd_reg <= reg_wdata[vtar_pkg::VTAR_MAP_LSB +: 7];
            end
        end
    end

    // row pointer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            table_row_pointer <= vtar_pkg::VTAR_RST_PTR;
        end else if (reg_wr && hit(reg_addr, vtar_pkg::VTAR_OFF_POINTER)) begin
            table_row_pointer <= reg_wdata[vtar_pkg::VTAR_PTR_LSB +: 12];
        end
    end

    // ----------------------------------------------------------------
    // command register
    // ----------------------------------------------------------------
    // command writes are dropped while busy so a running action keeps its code
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            action_reg <= vtar_pkg::ACT_NOP;
            start_reg <= 1'h0;
        end else if (!start_reg && reg_wr && hit(reg_addr, vtar_pkg::VTAR_OFF_CMD)) begin
            action_reg <= vtar_pkg::vtar_action_e'(reg_wdata[vtar_pkg::VTAR_ACT_LSB +: 2]);
            start_reg <= reg_wdata[vtar_pkg::VTAR_START_BIT];
        end else if (go && (action_reg == vtar_pkg::ACT_NOP
                         || action_reg == vtar_pkg::ACT_WRITE)) begin
            start_reg <= 1'h0;
        end else if (st_reg == vtar_pkg::ST_RDWAIT) begin
            start_reg <= 1'h0;
        end else if (st_reg == vtar_pkg::ST_CLEAR && sweep_reg == vtar_pkg::VTAR_LAST_ROW) begin
            start_reg <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // action sequencer
    // ----------------------------------------------------------------
    assign go = (st_reg == vtar_pkg::ST_IDLE) && start_reg;

    // read needs one wait for the ram; clear walks every row once
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= vtar_pkg::ST_IDLE;
        end else begin
            unique case (st_reg)
                vtar_pkg::ST_IDLE: begin
                    if (go && action_reg == vtar_pkg::ACT_READ) begin
                        st_reg <= vtar_pkg::ST_RDWAIT;
                    end else if (go && action_reg == vtar_pkg::ACT_CLEAR) begin
                        st_reg <= vtar_pkg::ST_CLEAR;
                    end
                end
                vtar_pkg::ST_RDWAIT: begin
                    st_reg <= vtar_pkg::ST_IDLE;
                end
                vtar_pkg::ST_CLEAR: begin
                    if (sweep_reg == vtar_pkg::VTAR_LAST_ROW) begin
                        st_reg <= vtar_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= vtar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sweep counter for the clear-all action
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sweep_reg <= vtar_pkg::VTAR_RST_PTR;
        end else if (st_reg == vtar_pkg::ST_CLEAR) begin
            sweep_reg <= sweep_reg + 12'h001;
        end else begin
            sweep_reg <= vtar_pkg::VTAR_RST_PTR;
        end
    end

    // ----------------------------------------------------------------
    // table port arbitration
    // ----------------------------------------------------------------
    // lookups only get the ram while no action is pending
    assign lkup_ready = (st_reg == vtar_pkg::ST_IDLE) && !start_reg;
    assign lk_take = lkup_req && lkup_ready;

    always_comb begin
        ram_we = 1'h0;
        ram_re = lk_take;
        ram_addr = lkup_row;
        ram_wdata = vtar_pkg::VTAR_ZERO_ENTRY;
        if (st_reg == vtar_pkg::ST_CLEAR) begin
            ram_we = 1'h1;
            ram_addr = sweep_reg;
        end else if (go) begin
            ram_addr = table_row_pointer;
            ram_we = (action_reg == vtar_pkg::ACT_WRITE);
            ram_re = (action_reg == vtar_pkg::ACT_READ);
            ram_wdata = pack_row(valid_reg, entry_map_select, prio_reg, msti_reg,
                                 fgid_reg, untag_reg, fwd_reg);
        end
    end

    vtar_table_ram u_ram (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ram_we(ram_we),
        .ram_re(ram_re),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata)
    );

    // ----------------------------------------------------------------
    // frame lookup result
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_pend_reg <= 1'h0;
            lk_alt_reg <= vtar_pkg::VTAR_RST_MAP;
        end else begin
            lk_pend_reg <= lk_take;
            if (lk_take) begin
                lk_alt_reg <= lkup_alt_map;
            end
        end
    end

    // invalid rows behave like a cleared selector and fall back to the other map
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lkup_valid <= 1'h0;
            lkup_hit <= 1'h0;
            lkup_fwd_map <= vtar_pkg::VTAR_RST_MAP;
            lkup_untag_map <= vtar_pkg::VTAR_RST_MAP;
            lkup_prio <= vtar_pkg::VTAR_RST_PRIO;
            spanning_instance_sel <= vtar_pkg::VTAR_RST_MSTI;
            filter_group_ident <= vtar_pkg::VTAR_RST_MAP;
        end else begin
            lkup_valid <= lk_pend_reg;
            if (lk_pend_reg) begin
                lkup_hit <= ram_rdata[vtar_pkg::VTAR_E_VALID];
                if (ram_rdata[vtar_pkg::VTAR_E_VALID] && ram_rdata[vtar_pkg::VTAR_E_SEL]) begin
                    lkup_fwd_map <= ram_rdata[vtar_pkg::VTAR_E_FWD +: 7];
                end else begin
                    lkup_fwd_map <= lk_alt_reg;
                end
                lkup_untag_map <= ram_rdata[vtar_pkg::VTAR_E_UNTAG +: 7];
                lkup_prio <= ram_rdata[vtar_pkg::VTAR_E_PRIO +: 3];
                spanning_instance_sel <= ram_rdata[vtar_pkg::VTAR_E_MSTI +: 3];
                filter_group_ident <= ram_rdata[vtar_pkg::VTAR_E_FGID +: 7];
            end
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    // data stand one cycle only; unmapped and idle cycles read zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (hit(reg_addr, vtar_pkg::VTAR_OFF_WORD0)) begin
            reg_rdata <= {valid_reg, 3'h0, entry_map_select, prio_reg, 9'h000,
                          msti_reg, 5'h00, fgid_reg};
        end else if (hit(reg_addr, vtar_pkg::VTAR_OFF_UNTAG)) begin
            reg_rdata <= {25'h000_0000, untag_reg};
        end else if (hit(reg_addr, vtar_pkg::VTAR_OFF_FWD)) begin
            reg_rdata <= {25'h000_0000, fwd_reg};
        end else if (hit(reg_addr, vtar_pkg::VTAR_OFF_POINTER)) begin
            reg_rdata <= {20'h0_0000, table_row_pointer};
        end else if (hit(reg_addr, vtar_pkg::VTAR_OFF_CMD)) begin
            reg_rdata <= {24'h00_0000, start_reg, 5'h00, action_reg};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking vtar_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence rd_go_s;
        go && action_reg == vtar_pkg::ACT_READ;
    endsequence

    sequence lk_go_s;
        lkup_req && lkup_ready;
    endsequence

    start_set_a: assert property ($rose(start_reg) |->
        $past(reg_wr && reg_addr == vtar_pkg::VTAR_OFF_CMD
        && reg_wdata[vtar_pkg::VTAR_START_BIT]))
        else $error("start bit rose without a command write");

    nop_done_a: assert property (go && action_reg == vtar_pkg::ACT_NOP |=> !start_reg)
        else $error("no-operation action did not finish at once");

    write_store_a: assert property (go && action_reg == vtar_pkg::ACT_WRITE |->
        ram_we && ram_addr == table_row_pointer && ram_wdata[28] == valid_reg
        && ram_wdata[6:0] == fwd_reg ##1 !start_reg)
        else $error("write action did not store the entry");

    read_load_a: assert property (rd_go_s |-> ram_addr == table_row_pointer
        ##1 st_reg == vtar_pkg::ST_RDWAIT
        ##1 !start_reg && valid_reg == $past(ram_rdata[28]) && untag_reg == $past(ram_rdata[13:7]))
        else $error("read action did not load the entry words");

    clear_zero_a: assert property (st_reg == vtar_pkg::ST_CLEAR |->
        ram_we && ram_wdata == vtar_pkg::VTAR_ZERO_ENTRY && ram_addr == sweep_reg && start_reg)
        else $error("clear sweep wrote a nonzero row");

    clear_end_a: assert property (st_reg == vtar_pkg::ST_CLEAR
        && sweep_reg == vtar_pkg::VTAR_LAST_ROW |=>
        !start_reg && st_reg == vtar_pkg::ST_IDLE)
        else $error("clear sweep did not end after the last row");

    lkup_fwd_a: assert property (lk_go_s ##1 (ram_rdata[28] && ram_rdata[27]) |=>
        lkup_valid && lkup_fwd_map == $past(ram_rdata[6:0]))
        else $error("selected entry map not used for forwarding");

    lkup_alt_a: assert property (lk_go_s ##1 !ram_rdata[27] |=>
        lkup_valid && lkup_fwd_map == $past(lkup_alt_map, 2))
        else $error("fallback port map not used");

    lkup_untag_a: assert property (lk_go_s |-> ##2 lkup_valid
        && lkup_untag_map == $past(ram_rdata[13:7]) && lkup_prio == $past(ram_rdata[26:24]))
        else $error("lookup untag map or priority wrong");

    cmd_read_a: assert property (reg_rd && reg_addr == vtar_pkg::VTAR_OFF_CMD |=>
        reg_rdata[7] == $past(start_reg) && reg_rdata[31:8] == 24'h00_0000)
        else $error("command read does not show the start bit");
endmodule // vtar_regs

// file: verif/tb_vlan_table_access_regs.sv
// self-checking bench for the vlan table access register block
`timescale 1ns/100ps
module tb_vlan_table_access_regs;
    // ----------------------------------------------------------------
    // clock, reset and design ports
    // ----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic lkup_req = 1'b0;
    logic [11:0] lkup_row = 12'h000;
    logic [6:0] lkup_alt_map = 7'h00;
    logic lkup_ready, lkup_valid, lkup_hit;
    logic [6:0] lkup_fwd_map, lkup_untag_map, filter_group_ident;
    logic [2:0] lkup_prio, spanning_instance_sel;
    int err_count = 0;
    int total_checks = 0;
    logic [31:0] d;
    logic [27:0] res;

    // 200 MHz core clock
    always #2.5 ref_clk = ~ref_clk;

    vtar_regs u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lkup_req(lkup_req), .lkup_row(lkup_row), .lkup_alt_map(lkup_alt_map),
        .lkup_ready(lkup_ready), .lkup_valid(lkup_valid), .lkup_hit(lkup_hit),
        .lkup_fwd_map(lkup_fwd_map), .lkup_untag_map(lkup_untag_map),
        .lkup_prio(lkup_prio), .spanning_instance_sel(spanning_instance_sel),
        .filter_group_ident(filter_group_ident));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe, released at the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // poll the start bit; bounded so that a stuck sequencer ends the run
    task automatic wait_done;
        logic [31:0] v;
        int n;
        v = 32'h0000_0080;
        n = 0;
        while (v[7] !== 1'b0 && n < 3000) begin
            rd(vtar_pkg::VTAR_OFF_CMD, v);
            n++;
        end
        if (v[7] !== 1'b0) begin
            err_count++;
            $display("[FAIL] start bit expected 0 seen %b", v[7]);
            complete_run();
        end
    endtask

    // load the entry words and pointer, then launch a write action
    task automatic put_row(input logic [11:0] row, input logic [31:0] w0,
        input logic [31:0] u, input logic [31:0] f);
        wr(vtar_pkg::VTAR_OFF_WORD0, w0);
        wr(vtar_pkg::VTAR_OFF_UNTAG, u);
        wr(vtar_pkg::VTAR_OFF_FWD, f);
        wr(vtar_pkg::VTAR_OFF_POINTER, {20'h00000, row});
        wr(vtar_pkg::VTAR_OFF_CMD, 32'h0000_0081);
        wait_done();
        rd(vtar_pkg::VTAR_OFF_CMD, d);
        chk("cmd after write", d, 32'h0000_0001);
    endtask

    // read action on a row, then compare all three entry words
    task automatic get_row(input logic [11:0] row, input logic [31:0] w0,
        input logic [31:0] u, input logic [31:0] f);
        wr(vtar_pkg::VTAR_OFF_POINTER, {20'h00000, row});
        wr(vtar_pkg::VTAR_OFF_CMD, 32'h0000_0082);
        wait_done();
        rd(vtar_pkg::VTAR_OFF_WORD0, d);
        chk("word0", d, w0);
        rd(vtar_pkg::VTAR_OFF_UNTAG, d);
        chk("untag", d, u);
        rd(vtar_pkg::VTAR_OFF_FWD, d);
        chk("fwd", d, f);
    endtask

    // lookup is taken at once while idle; result pulses two cycles later
    task automatic lookup(input logic [11:0] row, input logic [6:0] alt,
        output logic [27:0] r);
        @(posedge ref_clk);
        lkup_req <= 1'b1;
        lkup_row <= row;
        lkup_alt_map <= alt;
        #1 chk("lookup ready", {31'h0, lkup_ready}, 32'h0000_0001);
        @(posedge ref_clk);
        lkup_req <= 1'b0;
        // the pulse stands only in the cycle after the ram answers
        @(posedge ref_clk);
        #1 chk("lookup valid", {31'h0, lkup_valid}, 32'h0000_0001);
        r = {lkup_hit, lkup_fwd_map, lkup_untag_map, lkup_prio,
            spanning_instance_sel, filter_group_ident};
        @(posedge ref_clk);
        #1 chk("lookup pulse end", {31'h0, lkup_valid}, 32'h0000_0000);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // reset values, plus an unmapped address reading zero
    task automatic sc_reset_values;
        rd(vtar_pkg::VTAR_OFF_WORD0, d);
        chk("word0 reset", d, 32'h0000_0000);
        rd(vtar_pkg::VTAR_OFF_UNTAG, d);
        chk("untag reset", d, 32'h0000_0000);
        rd(vtar_pkg::VTAR_OFF_FWD, d);
        chk("fwd reset", d, 32'h0000_0000);
        rd(vtar_pkg::VTAR_OFF_POINTER, d);
        chk("pointer reset", d, 32'h0000_0000);
        rd(vtar_pkg::VTAR_OFF_CMD, d);
        chk("cmd reset", d, 32'h0000_0000);
        wr(16'h0410, 32'hFFFF_FFFF);
        rd(16'h0410, d);
        chk("unmapped", d, 32'h0000_0000);
    endtask

    // all-ones writes keep only the documented fields
    task automatic sc_field_widths;
        wr(vtar_pkg::VTAR_OFF_WORD0, 32'hFFFF_FFFF);
        wr(vtar_pkg::VTAR_OFF_UNTAG, 32'hFFFF_FFFF);
        wr(vtar_pkg::VTAR_OFF_FWD, 32'hFFFF_FFFF);
        wr(vtar_pkg::VTAR_OFF_POINTER, 32'hFFFF_FFFF);
        rd(vtar_pkg::VTAR_OFF_WORD0, d);
        chk("word0 fields", d, 32'h8F00_707F);
        rd(vtar_pkg::VTAR_OFF_UNTAG, d);
        chk("untag fields", d, 32'h0000_007F);
        rd(vtar_pkg::VTAR_OFF_FWD, d);
        chk("fwd fields", d, 32'h0000_007F);
        rd(vtar_pkg::VTAR_OFF_POINTER, d);
        chk("pointer fields", d, 32'h0000_0FFF);
    endtask

    // a stored row must read back zero after clear-all
    task automatic sc_clear_all;
        put_row(12'h005, 32'h8D00_302A, 32'h0000_0055, 32'h0000_0033);
        wr(vtar_pkg::VTAR_OFF_CMD, 32'h0000_0083);
        rd(vtar_pkg::VTAR_OFF_CMD, d);
        chk("cmd busy", d, 32'h0000_0083);
        chk("ready while busy", {31'h0, lkup_ready}, 32'h0000_0000);
        wait_done();
        get_row(12'h005, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    endtask

    // two rows, row 005 and the last pointer row, read back in write order
    task automatic sc_write_read;
        put_row(12'h005, 32'h8D00_302A, 32'h0000_0055, 32'h0000_0033);
        put_row(12'hFFF, 32'h8200_6011, 32'h0000_000F, 32'h0000_0070);
        get_row(12'h005, 32'h8D00_302A, 32'h0000_0055, 32'h0000_0033);
        get_row(12'hFFF, 32'h8200_6011, 32'h0000_000F, 32'h0000_0070);
    endtask

    // selector set uses entry map; clear or invalid row uses fallback
    task automatic sc_lookup;
        lookup(12'h005, 7'h01, res);
        chk("lookup sel", {4'h0, res}, {4'h0, 1'b1, 7'h33, 7'h55, 3'h5, 3'h3, 7'h2A});
        lookup(12'hFFF, 7'h0C, res);
        chk("lookup alt", {4'h0, res}, {4'h0, 1'b1, 7'h0C, 7'h0F, 3'h2, 3'h6, 7'h11});
        lookup(12'h100, 7'h7E, res);
        chk("lookup invalid", {4'h0, res}, {4'h0, 1'b0, 7'h7E, 7'h00, 3'h0, 3'h0, 7'h00});
    endtask

    // no-op action finishes and leaves the entry words alone
    task automatic sc_nop;
        wr(vtar_pkg::VTAR_OFF_WORD0, 32'h8100_1001);
        wr(vtar_pkg::VTAR_OFF_CMD, 32'h0000_0080);
        wait_done();
        rd(vtar_pkg::VTAR_OFF_WORD0, d);
        chk("nop word0", d, 32'h8100_1001);
        rd(vtar_pkg::VTAR_OFF_CMD, d);
        chk("nop cmd", d, 32'h0000_0000);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        sc_reset_values();
        sc_field_widths();
        sc_clear_all();
        sc_write_read();
        sc_lookup();
        sc_nop();
        repeat (4) @(posedge ref_clk);
        complete_run();
    end
endmodule // tb_vlan_table_access_regs
